// ===== logic/etg_pkg.sv
package etg_pkg;

	// ****************************************************************
	// Register offsets (management register space)
	// ****************************************************************
	localparam logic [15:0] OFF_IRQ_MASK   = 16'h0018;
	localparam logic [15:0] OFF_IRQ_STATUS = 16'h0019;
	localparam logic [15:0] OFF_ENABLE     = 16'h9415;
	localparam logic [15:0] OFF_CTRL       = 16'h9416;
	localparam logic [15:0] OFF_CONT       = 16'h9417;
	localparam logic [15:0] OFF_IRQ_EN     = 16'h9418;
	localparam logic [15:0] OFF_LEN        = 16'h941a;
	localparam logic [15:0] OFF_GAP        = 16'h941b;
	localparam logic [15:0] OFF_CNT_UPPER  = 16'h941c;
	localparam logic [15:0] OFF_CNT_LOWER  = 16'h941d;
	localparam logic [15:0] OFF_DONE       = 16'h941e;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [2:0]  RST_PATTERN   = 3'h1;
	localparam logic [15:0] RST_LEN       = 16'h006b;
	localparam logic [7:0]  RST_GAP       = 8'h0c;
	localparam logic [15:0] RST_CNT_UPPER = 16'h0000;
	localparam logic [15:0] RST_CNT_LOWER = 16'h0100;
	localparam int          RESTART_BIT   = 3;
	localparam int          IRQ_BIT       = 7;

	// ****************************************************************
	// Data field pattern codes
	// ****************************************************************
	localparam logic [2:0] PAT_STOP   = 3'h0;
	localparam logic [2:0] PAT_RANDOM = 3'h1;
	localparam logic [2:0] PAT_ZEROS  = 3'h2;
	localparam logic [2:0] PAT_ONES   = 3'h3;
	localparam logic [2:0] PAT_ALT    = 3'h4;
	localparam logic [2:0] PAT_DECR   = 3'h5;

	localparam logic [7:0] BYTE_ZEROS = 8'h00;
	localparam logic [7:0] BYTE_ONES  = 8'hff;
	localparam logic [7:0] BYTE_ALT   = 8'h55;
	localparam logic [7:0] BYTE_DECR0 = 8'hff;

	// ****************************************************************
	// Frame layout
	// ****************************************************************
	localparam logic [15:0] DA_LAST  = 16'h0005;  // Destination bytes 0..5
	localparam logic [15:0] SA_LAST  = 16'h000b;  // Source bytes 6..11
	localparam logic [15:0] HDR_LAST = 16'h000d;  // Length field bytes 12..13
	localparam logic [15:0] FCS_LAST = 16'h0003;
	localparam logic [47:0] DEST_ADDR = 48'hffff_ffff_ffff;
	// Source address value is arbitrary
	localparam logic [47:0] SRC_ADDR  = 48'h0200_0000_0001;

	localparam logic [31:0] CRC_INIT  = 32'hffff_ffff;
	localparam logic [31:0] CRC_POLY  = 32'hedb8_8320;
	localparam logic [15:0] LFSR_SEED = 16'hace1;

	// FIFO between the sequencer and the transmit path
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 8;

	// Sequencer states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_HDR  = 5'h02,
		ST_DATA = 5'h04,
		ST_FCS  = 5'h08,
		ST_GAP  = 5'h10
	} etg_state_e;

endpackage

// ===== logic/etg_fifo.sv
module etg_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// Filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	wire              push = in_valid_i & in_ready_o;
	wire              pop  = out_valid_o & out_ready_i;

	// Full and empty come straight from the fill count
	assign in_ready_o  = fill != (AW+1)'(DEPTH);
	assign out_valid_o = fill != '0;
	assign out_data_o  = mem[rd_ptr];

	// Storage has no reset; only the pointers and the fill count need one
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers wrap on depth, which need not be a power of two
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// ===== logic/etg_gen.sv
module etg_gen
	import etg_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Management register port
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	// MAC transmit side
	input  wire logic [7:0]  mac_txd_i,
	input  wire logic        mac_tx_en_i,
	// Transmit datapath toward the line
	input  wire logic        tx_ready_i,
	output logic      [7:0]  tx_data_o,
	output logic             tx_en_o,
	// Device interrupt
	output logic             irq_o
);

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Reflected CRC-32, one byte, least significant bit first
	function automatic logic [31:0] crc_byte(input logic [31:0] crc, input logic [7:0] d);
		logic [31:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// Header byte at a given position in the frame
	function automatic logic [7:0] hdr_byte(input logic [15:0] idx, input logic [15:0] len);
		logic [7:0] b;
		b = BYTE_ZEROS;
		if (idx <= DA_LAST) begin
			b = DEST_ADDR[8'(DA_LAST - idx) * 8 +: 8];
		end else if (idx <= SA_LAST) begin
			b = SRC_ADDR[8'(SA_LAST - idx) * 8 +: 8];
		end else if (idx == HDR_LAST) begin
			b = len[7:0];
		end else begin
			b = len[15:8];
		end
		return b;
	endfunction

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic        gen_enable;
	logic [2:0]  gen_pattern_select;
	logic        gen_continuous;
	logic        gen_interrupt_enable;
	logic [15:0] gen_payload_length;
	logic [7:0]  gen_gap_length;
	logic [15:0] gen_frame_count_upper;
	logic [15:0] gen_frame_count_lower;
	logic        gen_complete;
	logic        checker_generator_irq_mask;
	logic        checker_generator_irq_pending;

	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	etg_state_e  state;
	etg_state_e  next_state;
	logic [15:0] idx;
	logic [15:0] next_idx;
	logic [31:0] frames_left;
	logic [31:0] crc;
	logic [15:0] lfsr;
	logic [7:0]  decr;
	logic        done_evt;
	logic [7:0]  seq_byte;
	logic        seq_is_data;

	// FIFO wires
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [8:0]  fifo_out_data;

	// Address decode
	wire hit_enable   = reg_addr_i == OFF_ENABLE;
	wire hit_ctrl     = reg_addr_i == OFF_CTRL;
	wire hit_cont     = reg_addr_i == OFF_CONT;
	wire hit_irq_en   = reg_addr_i == OFF_IRQ_EN;
	wire hit_len      = reg_addr_i == OFF_LEN;
	wire hit_gap      = reg_addr_i == OFF_GAP;
	wire hit_upper    = reg_addr_i == OFF_CNT_UPPER;
	wire hit_lower    = reg_addr_i == OFF_CNT_LOWER;
	wire hit_done     = reg_addr_i == OFF_DONE;
	wire hit_mask     = reg_addr_i == OFF_IRQ_MASK;
	wire hit_status   = reg_addr_i == OFF_IRQ_STATUS;

	// Start on a rising enable or a restart write; restart is a pulse, never stored
	wire restart_pulse = reg_wr_i & hit_ctrl & reg_wdata_i[RESTART_BIT];
	wire enable_rise   = reg_wr_i & hit_enable & reg_wdata_i[0] & ~gen_enable;
	wire start         = restart_pulse | enable_rise;
	wire [2:0] start_pattern = (reg_wr_i & hit_ctrl) ? reg_wdata_i[2:0] : gen_pattern_select;
	wire [31:0] burst_count = {gen_frame_count_upper, gen_frame_count_lower};

	// Sequencer progress is throttled by FIFO space, so back-pressure stalls it
	wire active  = state != ST_IDLE;
	wire step    = active & fifo_in_ready & ~start;
	wire last_frame  = ~gen_continuous & (frames_left == 32'h1);
	wire stop_req    = (gen_pattern_select == PAT_STOP) | ~gen_enable;
	wire data_last   = idx == gen_payload_length - 16'h1;
	wire gap_last    = idx == {8'h00, gen_gap_length} - 16'h1;
	wire fcs_last    = idx == FCS_LAST;
	wire burst_empty = ~gen_continuous & (burst_count == 32'h0);
	wire [7:0] fcs_b = ~crc[{idx[1:0], 3'h0} +: 8];

	// Data field byte by pattern code
	wire [7:0] data_b =
		(gen_pattern_select == PAT_DECR)   ? decr :
		(gen_pattern_select == PAT_ALT)    ? BYTE_ALT :
		(gen_pattern_select == PAT_ONES)   ? BYTE_ONES :
		(gen_pattern_select == PAT_RANDOM) ? lfsr[7:0] :
		BYTE_ZEROS;

	// ****************************************************************
	// Byte source and next state
	// ****************************************************************

	// The byte offered to the FIFO in the current state
	always_comb begin
		seq_byte    = BYTE_ZEROS;
		seq_is_data = 1'b1;
		case (state)
			ST_HDR:  seq_byte = hdr_byte(idx, gen_payload_length);
			ST_DATA: seq_byte = data_b;
			ST_FCS:  seq_byte = fcs_b;
			ST_GAP:  seq_is_data = 1'b0;
			default: seq_is_data = 1'b0;
		endcase
	end

	// Next state; an empty payload skips straight to the check sequence
	always_comb begin
		next_state = state;
		next_idx   = idx + 16'h1;
		done_evt   = 1'b0;
		case (state)
			ST_IDLE: begin
				next_idx = idx;
			end
			ST_HDR: begin
				if (idx == HDR_LAST) begin
					next_idx   = 16'h0;
					next_state = (gen_payload_length == 16'h0) ? ST_FCS : ST_DATA;
				end
			end
			ST_DATA: begin
				if (data_last) begin
					next_idx   = 16'h0;
					next_state = ST_FCS;
				end
			end
			ST_FCS: begin
				if (fcs_last) begin
					next_idx = 16'h0;
					if (last_frame) begin
						done_evt   = 1'b1;
						next_state = ST_IDLE;
					end else if (stop_req) begin
						next_state = ST_IDLE;
					end else if (gen_gap_length == 8'h00) begin
						next_state = ST_HDR;
					end else begin
						next_state = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				if (gap_last) begin
					next_idx   = 16'h0;
					next_state = stop_req ? ST_IDLE : ST_HDR;
				end
			end
			default: begin
				next_idx   = 16'h0;
				next_state = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Sequencer registers
	// ****************************************************************

	// Start reloads count, checksum and patterns from the beginning
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state       <= ST_IDLE;
			idx         <= 16'h0;
			frames_left <= 32'h0;
		end else if (start) begin
			state       <= (start_pattern == PAT_STOP || burst_empty) ? ST_IDLE : ST_HDR;
			idx         <= 16'h0;
			frames_left <= burst_count;
		end else if (step) begin
			state <= next_state;
			idx   <= next_idx;
			if (state == ST_FCS && fcs_last) begin
				frames_left <= frames_left - 32'h1;
			end
		end
	end

	// Running checksum and pattern generators; checksum and decrementing pattern restart with each frame, the random one only at start
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			crc  <= CRC_INIT;
			lfsr <= LFSR_SEED;
			decr <= BYTE_DECR0;
		end else if (start) begin
			crc  <= CRC_INIT;
			lfsr <= LFSR_SEED;
			decr <= BYTE_DECR0;
		end else if (step) begin
			if (state == ST_HDR || state == ST_DATA) begin
				crc <= crc_byte(crc, seq_byte);
			end else if (state == ST_FCS && fcs_last) begin
				crc <= CRC_INIT;
			end
			if (state == ST_DATA) begin
				lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
				decr <= decr - 8'h01;
			end else if (state == ST_FCS) begin
				decr <= BYTE_DECR0;
			end
		end
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************

	// Software-written configuration; restart bit is not held
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gen_enable                 <= 1'b0;
			gen_pattern_select         <= RST_PATTERN;
			gen_continuous             <= 1'b0;
			gen_interrupt_enable       <= 1'b0;
			gen_payload_length         <= RST_LEN;
			gen_gap_length             <= RST_GAP;
			gen_frame_count_upper      <= RST_CNT_UPPER;
			gen_frame_count_lower      <= RST_CNT_LOWER;
			checker_generator_irq_mask <= 1'b0;
		end else if (reg_wr_i) begin
			if (hit_enable)   gen_enable <= reg_wdata_i[0];
			if (hit_ctrl)     gen_pattern_select <= reg_wdata_i[2:0];
			if (hit_cont)     gen_continuous <= reg_wdata_i[0];
			if (hit_irq_en)   gen_interrupt_enable <= reg_wdata_i[0];
			if (hit_len)      gen_payload_length <= reg_wdata_i;
			if (hit_gap)      gen_gap_length <= reg_wdata_i[7:0];
			if (hit_upper)    gen_frame_count_upper <= reg_wdata_i;
			if (hit_lower)    gen_frame_count_lower <= reg_wdata_i;
			if (hit_mask)     checker_generator_irq_mask <= reg_wdata_i[IRQ_BIT];
		end
	end

	// Sticky flags: a new completion in the clearing read cycle wins
	wire done_now = (step & done_evt) | (start & burst_empty & start_pattern != PAT_STOP);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gen_complete                  <= 1'b0;
			checker_generator_irq_pending <= 1'b0;
		end else begin
			if (done_now) begin
				gen_complete <= 1'b1;
			end else if (reg_rd_i && hit_done) begin
				gen_complete <= 1'b0;
			end
			if (done_now && gen_interrupt_enable) begin
				checker_generator_irq_pending <= 1'b1;
			end else if (reg_rd_i && hit_status) begin
				checker_generator_irq_pending <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************

	// Reserved bits and unmapped addresses read as zero
	wire [15:0] rd_mux =
		hit_enable ? {15'h0, gen_enable} :
		hit_ctrl   ? {13'h0, gen_pattern_select} :
		hit_cont   ? {15'h0, gen_continuous} :
		hit_irq_en ? {15'h0, gen_interrupt_enable} :
		hit_len    ? gen_payload_length :
		hit_gap    ? {8'h00, gen_gap_length} :
		hit_upper  ? gen_frame_count_upper :
		hit_lower  ? gen_frame_count_lower :
		hit_done   ? {15'h0, gen_complete} :
		hit_mask   ? {8'h00, checker_generator_irq_mask, 7'h00} :
		hit_status ? {8'h00, checker_generator_irq_pending, 7'h00} :
		16'h0000;

	// Read data is registered, valid the cycle after the read strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end

	// ****************************************************************
	// Transmit path
	// ****************************************************************

	// Leftover bytes drain and are discarded once the generator is off
	wire fifo_out_ready = tx_ready_i | ~gen_enable;
	wire fifo_pop       = fifo_out_valid & fifo_out_ready;

	etg_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (step),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({seq_is_data, seq_byte}),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data)
	);

	// Source select: generator when enabled, MAC otherwise
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_en_o   <= 1'b0;
			tx_data_o <= 8'h00;
		end else if (gen_enable) begin
			tx_en_o   <= fifo_pop & fifo_out_data[8];
			tx_data_o <= fifo_pop ? fifo_out_data[7:0] : 8'h00;
		end else begin
			tx_en_o   <= mac_tx_en_i;
			tx_data_o <= mac_txd_i;
		end
	end

	// Interrupt output gated by the shared mask
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= checker_generator_irq_pending & checker_generator_irq_mask;
		end
	end

endmodule

// ===== test/etg_gen_checker.sv
// ****
// Port checker for the frame generator
// ****
module etg_gen_checker
	import etg_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// Register port
	input wire logic [15:0] reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	// Data paths and interrupt
	input wire logic [7:0]  mac_txd_i,
	input wire logic        mac_tx_en_i,
	input wire logic        tx_ready_i,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_en_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Address decodes used by several properties
	wire logic rd_ctrl = reg_rd_i && reg_addr_i == OFF_CTRL;
	wire logic rd_cont = reg_rd_i && reg_addr_i == OFF_CONT;
	wire logic rd_gap  = reg_rd_i && reg_addr_i == OFF_GAP;
	wire logic rd_stat = reg_rd_i && reg_addr_i == OFF_IRQ_STATUS;

	logic mask_q;
	logic en_q;

	// Shadow of mask and enable, so output gating can be judged
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mask_q <= 1'b0;
			en_q   <= 1'b0;
		end else if (reg_wr_i) begin
			if (reg_addr_i == OFF_IRQ_MASK)
				mask_q <= reg_wdata_i[IRQ_BIT];
			if (reg_addr_i == OFF_ENABLE)
				en_q <= reg_wdata_i[0];
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_restart_self_clear: assert property (rd_ctrl |=> reg_rdata_o[15:3] == 13'h0000)
		else $error("restart or reserved control bits read set");
	a_cont_reserved: assert property (rd_cont |=> reg_rdata_o[15:1] == 15'h0000)
		else $error("mode register reserved bits read set");
	a_gap_reserved: assert property (rd_gap |=> reg_rdata_o[15:8] == 8'h00)
		else $error("gap register upper byte read set");
	a_status_bits: assert property (rd_stat |=> (reg_rdata_o & 16'hff7f) == 16'h0000)
		else $error("status has bits besides bit 7");
	a_len_readback: assert property (
		reg_wr_i && reg_addr_i == OFF_LEN ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == OFF_LEN
		|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("length field lost the written value");
	a_cnt_readback: assert property (
		reg_wr_i && reg_addr_i == OFF_CNT_UPPER ##1 !reg_wr_i
		##1 reg_rd_i && reg_addr_i == OFF_CNT_UPPER
		|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("upper count half lost the written value");
	a_irq_masked: assert property (!$past(mask_q) |-> !irq_o)
		else $error("interrupt raised while masked");
	a_mac_passthru: assert property (!$past(en_q) |-> tx_en_o == $past(mac_tx_en_i)
		&& (!tx_en_o || tx_data_o == $past(mac_txd_i)))
		else $error("disabled output does not follow the MAC");
endmodule

// ===== test/etg_line_model.sv
// ****
// Line side of the transmit path
// ****
module etg_line_model (
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_b_i,
	// Stall control
	input  wire logic   random_i,
	input  wire logic   rnd_i,
	// Transmit byte stream
	input  wire logic   tx_en_i,
	output logic        tx_ready_o,
	output logic [15:0] frames_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic en_d;

	// Ready is either steady or random; a frame is counted at each start of bytes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_ready_o <= 1'b0;
			en_d       <= 1'b0;
			frames_o   <= 16'h0000;
		end else begin
			tx_ready_o <= random_i ? rnd_i : 1'b1;
			en_d       <= tx_en_i;
			if (tx_en_i && !en_d)
				frames_o <= frames_o + 16'h0001;
		end
	end
endmodule

// ===== test/test_ethernet_test_frame_generator.sv
// ****
// Self-checking bench
// ****
module test_ethernet_test_frame_generator
	import etg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [15:0] reg_rdata_o;
	logic [7:0]  mac_txd_i = 8'h00;
	logic        mac_tx_en_i = 1'b0;
	logic        tx_ready_i;
	logic [7:0]  tx_data_o;
	logic        tx_en_o;
	logic        irq_o;
	logic [15:0] lfsr = 16'he2e3;
	logic        rnd_mode = 1'b0;
	logic [15:0] frames;
	logic [15:0] base;
	logic [8:0]  mx;
	logic [15:0] exp_rd[$];
	logic [8:0]  exp_tx[$];
	logic        rd_d = 1'b0;
	logic        rd_dd = 1'b0;
	logic        mon_on = 1'b1;
	logic        gap_on = 1'b0;
	logic        seen = 1'b0;
	int          idle = 0;
	int          n_rnd = 0;
	int          mismatches = 0;
	int          n_tests = 0;
	logic [15:0] offs[12] = '{OFF_ENABLE, OFF_CTRL, OFF_CONT, OFF_IRQ_EN, OFF_LEN, OFF_GAP,
		OFF_CNT_UPPER, OFF_CNT_LOWER, OFF_DONE, OFF_IRQ_MASK, OFF_IRQ_STATUS, 16'h9419};
	logic [15:0] rsts[12] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h006b, 16'h000c,
		16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic [2:0]  pats[3] = '{3'b010, 3'b011, 3'b001};

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	etg_gen DUT (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
		.reg_rdata_o, .mac_txd_i, .mac_tx_en_i, .tx_ready_i, .tx_data_o, .tx_en_o, .irq_o);
	etg_line_model u_line (.clk_i, .rst_b_i, .random_i(rnd_mode), .rnd_i(lfsr[0]),
		.tx_en_i(tx_en_o), .tx_ready_o(tx_ready_i), .frames_o(frames));

	// ****
	// Helpers
	// ****
	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		c = c ^ {24'h000000, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
		return c;
	endfunction

	function automatic logic [7:0] fill(input logic [2:0] p, input int k);
		case (p)
			3'b101: return 8'hff - 8'(k);
			3'b100: return 8'h55;
			3'b011: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction

	// Notes a whole frame; random data and its check sequence are not predictable
	function automatic void push_frame(input logic [15:0] len, input logic [2:0] pat);
		logic [31:0] c;
		logic [7:0]  b;
		c = 32'hffffffff;
		for (int i = 0; i < 14 + int'(len); i++) begin
			if (i < 6)
				b = 8'hff;
			else if (i < 12)
				b = SRC_ADDR[8 * (11 - i) +: 8];
			else if (i == 12)
				b = len[15:8];
			else if (i == 13)
				b = len[7:0];
			else
				b = fill(pat, i - 14);
			c = crc_step(c, b);
			exp_tx.push_back({pat == 3'b001 && i > 13, b});
		end
		c = ~c;
		for (int j = 0; j < 4; j++)
			exp_tx.push_back({pat == 3'b001, c[8 * j +: 8]});
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		exp_rd.push_back(e);
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
	endtask

	// Waits, bounded, until every noted byte has been seen
	task automatic drain;
		int n;
		n = 0;
		while (exp_tx.size() != 0 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (exp_tx.size() != 0) begin
			mismatches++;
			$display("[FAIL] drain expected 0 seen %0d", exp_tx.size());
		end
		repeat (20) @(posedge clk_i);
	endtask

	task automatic end_sim;
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Random source and read-answer timing
	always @(posedge clk_i) begin
		lfsr  <= lfsr_next(lfsr);
		rd_d  <= reg_rd_i;
		rd_dd <= rd_d;
	end

	// Monitor: results are compared with the oldest note, at the falling edge
	always @(negedge clk_i) begin
		if (rd_dd)
			chk("reg_rdata_o", exp_rd.pop_front(), reg_rdata_o);
		if (mon_on && tx_en_o === 1'b1) begin
			if (exp_tx.size() == 0)
				chk("tx_data_o", 16'h0100, {8'h00, tx_data_o});
			else begin
				mx = exp_tx.pop_front();
				if (!mx[8])
					chk("tx_data_o", {8'h00, mx[7:0]}, {8'h00, tx_data_o});
				else if (tx_data_o != 8'h00)
					n_rnd++;
			end
		end
		if (gap_on && tx_en_o === 1'b1) begin
			if (seen && idle > 0)
				chk("gap", 16'h0004, 16'(idle));
			seen = 1'b1;
			idle = 0;
		end else if (gap_on && seen)
			idle++;
	end

	// Watchdog against a hang
	initial begin
		#1500000;
		mismatches++;
		$display("[FAIL] watchdog expected end seen timeout");
		end_sim;
	end

	// ****
	// Scenarios
	// ****
	initial begin
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		foreach (offs[i]) rd(offs[i], rsts[i]);
		wr(OFF_CTRL, 16'h000c);
		rd(OFF_CTRL, 16'h0004);
		wr(OFF_GAP, 16'hffff);
		rd(OFF_GAP, 16'h00ff);
		wr(OFF_LEN, 16'h1234);
		rd(OFF_LEN, 16'h1234);
		wr(OFF_CNT_UPPER, 16'ha5c3);
		rd(OFF_CNT_UPPER, 16'ha5c3);
		wr(OFF_CNT_UPPER, 16'h0000);
		wr(OFF_CONT, 16'hffff);
		rd(OFF_CONT, 16'h0001);
		wr(OFF_CONT, 16'h0000);
		// MAC bytes pass while the generator is off
		repeat (16) begin
			@(posedge clk_i);
			mac_tx_en_i <= lfsr[0];
			mac_txd_i   <= lfsr[15:8];
			if (lfsr[0])
				exp_tx.push_back({1'b0, lfsr[15:8]});
		end
		@(posedge clk_i);
		mac_tx_en_i <= 1'b0;
		drain;
		// Burst of two frames with interrupt and gap
		wr(OFF_IRQ_MASK, 16'h0080);
		wr(OFF_IRQ_EN, 16'h0001);
		wr(OFF_CTRL, 16'h0004);
		wr(OFF_LEN, 16'h0003);
		wr(OFF_GAP, 16'h0004);
		wr(OFF_CNT_LOWER, 16'h0002);
		repeat (2) push_frame(16'h0003, 3'b100);
		gap_on = 1'b1;
		wr(OFF_ENABLE, 16'h0001);
		drain;
		gap_on = 1'b0;
		chk("irq_o", 16'h0001, {15'h0000, irq_o});
		rd(OFF_DONE, 16'h0001);
		rd(OFF_DONE, 16'h0000);
		rd(OFF_IRQ_STATUS, 16'h0080);
		rd(OFF_IRQ_STATUS, 16'h0000);
		repeat (4) @(posedge clk_i);
		chk("irq_o", 16'h0000, {15'h0000, irq_o});
		// Restart, long wrapping frame, random stalls fill the buffer
		rnd_mode <= 1'b1;
		wr(OFF_LEN, 16'h0102);
		wr(OFF_CNT_LOWER, 16'h0001);
		push_frame(16'h0102, 3'b101);
		wr(OFF_CTRL, 16'h000d);
		drain;
		rd(OFF_DONE, 16'h0001);
		rd(OFF_IRQ_STATUS, 16'h0080);
		wr(OFF_IRQ_EN, 16'h0000);
		wr(OFF_LEN, 16'h0005);
		foreach (pats[i]) begin
			push_frame(16'h0005, pats[i]);
			wr(OFF_CTRL, {12'h000, 1'b1, pats[i]});
			drain;
			rd(OFF_DONE, 16'h0001);
		end
		chk("random", 16'h0001, {15'h0000, n_rnd > 4});
		rd(OFF_IRQ_STATUS, 16'h0000);
		// A zero count completes without frames
		wr(OFF_CNT_LOWER, 16'h0000);
		wr(OFF_CTRL, 16'h000b);
		drain;
		rd(OFF_DONE, 16'h0001);
		// Continuous run outlives the count, then the stop code ends it
		rnd_mode <= 1'b0;
		mon_on = 1'b0;
		wr(OFF_CONT, 16'h0001);
		wr(OFF_CNT_LOWER, 16'h0001);
		wr(OFF_LEN, 16'h0001);
		base = frames;
		wr(OFF_CTRL, 16'h000b);
		repeat (200) @(posedge clk_i);
		chk("frames", 16'h0001, {15'h0000, frames - base > 16'h0002});
		wr(OFF_CTRL, 16'h0000);
		repeat (60) @(posedge clk_i);
		base = frames;
		repeat (100) @(posedge clk_i);
		chk("frames", base, frames);
		rd(OFF_DONE, 16'h0000);
		wr(OFF_ENABLE, 16'h0000);
		repeat (4) @(posedge clk_i);
		end_sim;
	end
endmodule

bind etg_gen etg_gen_checker u_chk (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
	.reg_wdata_i, .reg_rdata_o, .mac_txd_i, .mac_tx_en_i, .tx_ready_i, .tx_data_o,
	.tx_en_o, .irq_o);
